// [verilog/bsea_consts.vh]
// Constants for the battery status and alarm word block.
// Assumes temperatures in units of 0.1 K and capacities/times in the same unit as their limits.
`ifndef BSEA_CONSTS_VH
`define BSEA_CONSTS_VH

// Command code of the status word
`define BSEA_CMD_STATUS 8'h16

// Error field codes
`define BSEA_ERR_OK 4'h0
`define BSEA_ERR_BUSY 4'h1
`define BSEA_ERR_RETRY 4'h2
`define BSEA_ERR_UNSUPPORTED 4'h3
`define BSEA_ERR_ACCESS_DENIED 4'h4
`define BSEA_ERR_OVER_UNDER 4'h5
`define BSEA_ERR_BAD_SIZE 4'h6
`define BSEA_ERR_UNKNOWN 4'h7

// Status word layout
`define BSEA_ERR_MSB 3
`define BSEA_ERR_LSB 0
`define BSEA_B_OVER_CHARGED 15
`define BSEA_B_TERM_CHARGE 14
`define BSEA_B_OVER_TEMP 12
`define BSEA_B_TERM_DISCHARGE 11
`define BSEA_B_REM_CAP 9
`define BSEA_B_REM_TIME 8
`define BSEA_B_INITIALIZED 7
`define BSEA_B_DISCHARGING 6
`define BSEA_B_FULLY_CHARGED 5
`define BSEA_B_FULLY_DISCHARGED 4
`define BSEA_STATUS_RST 16'h0000

// Serial memory image checks and status init bytes
`define BSEA_EE_LEN_ADDR 8'h00
`define BSEA_EE_LEN_VAL 8'h64
`define BSEA_EE_CHK_ADDR 8'h01
`define BSEA_EE_CHK_VAL 8'h5b
`define BSEA_EE_STAT_LO 8'h0c
`define BSEA_EE_STAT_HI 8'h0d
`define BSEA_EE_INIT_BIT 7

// Temperature thresholds: 43 C and 5 C hysteresis, in 0.1 K
`define BSEA_OT_CLR_C 16'h002b
`define BSEA_OT_HYST_C 16'h0005
`define BSEA_DK_PER_C 16'h000a
`define BSEA_ZERO_C_DK 16'h0aab

// Relative charge at which fully discharged clears: 20 percent
`define BSEA_FD_CLR_PCT 7'h14

`endif

// [verilog/bsea_flag.v]
// One status or alarm bit with load, set and clear.
// Assumes all controls are synchronous to core_clk.
`timescale 1ns/1ps

module bsea_flag (
    input wire core_clk,
    input wire sys_rst,
    input wire load,
    input wire load_val,
    input wire set,
    input wire clr,
    output wire q
);
    reg flag_q;
    reg flag_d;

    // Load beats all; an event in the clearing cycle is kept (set beats clear)
    always @* begin
        flag_d = flag_q;
        if (load) begin
            flag_d = load_val;
        end else if (set) begin
            flag_d = 1'b1;
        end else if (clr) begin
            flag_d = 1'b0;
        end
    end

    // State held in one flop
    always @(posedge core_clk) begin
        if (sys_rst) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign q = flag_q;
endmodule // bsea_flag

// [verilog/bsea_status.v]
// Battery status word: error field plus alarm and status bits.
// Assumes the serial bus engine, memory loader and gauge logic share core_clk.
`timescale 1ns/1ps
`include "bsea_consts.vh"

module bsea_status #(
    parameter W = 16
) (
    input wire core_clk,
    input wire sys_rst,
    input wire ee_load_start,
    input wire ee_byte_valid,
    input wire [7:0] ee_byte_addr,
    input wire [7:0] ee_byte_data,
    input wire ee_load_done,
    input wire ee_load_fail,
    input wire cmd_done,
    input wire cmd_write,
    input wire [7:0] cmd_code,
    input wire cmd_supported,
    input wire cmd_read_only,
    input wire cmd_busy,
    input wire cmd_retry,
    input wire cmd_bad_size,
    input wire cmd_range_err,
    input wire cmd_other_err,
    input wire is_charging,
    input wire valid_charge,
    input wire dtdt_term,
    input wire taper_term,
    input wire over_current,
    input wire over_voltage,
    input wire max_overcharge,
    input wire [W-1:0] temperature,
    input wire [W-1:0] max_temperature,
    input wire [W-1:0] pack_voltage,
    input wire [W-1:0] final_discharge_voltage_threshold,
    input wire [W-1:0] remaining_capacity_count,
    input wire [W-1:0] capacity_alarm_level,
    input wire [W-1:0] full_charge_level,
    input wire [W-1:0] remaining_time_est,
    input wire [W-1:0] time_alarm_level,
    input wire [W-1:0] avg_time_to_empty,
    input wire [6:0] relative_soc,
    output wire [15:0] battery_status_word,
    output wire eeprom_valid,
    output wire error_pending
);
    localparam [1:0] EE_IDLE = 2'b00;
    localparam [1:0] EE_LOAD = 2'b01;
    localparam [1:0] EE_GOOD = 2'b10;
    localparam [1:0] EE_BAD = 2'b11;

    // Temperature limit in 0.1 K, guarded against wrap below zero
    function [W-1:0] minus_c;
        input [W-1:0] t_dk;
        input [15:0] c;
        reg [W-1:0] d;
        begin
            d = c * `BSEA_DK_PER_C;
            minus_c = (t_dk > d) ? (t_dk - d) : {W{1'b0}};
        end
    endfunction

    reg [1:0] ee_state_q;
    reg [1:0] ee_state_d;
    reg len_ok_q;
    reg chk_ok_q;
    reg [15:0] init_word_q;
    reg eeprom_valid_q;
    reg [3:0] err_q;
    reg [3:0] err_d;
    reg err_pend_q;
    reg term_q;
    reg [W-1:0] rm_prev_q;
    wire run;
    wire load_good;
    wire load_bad;
    wire term_now;
    wire term_rise;
    wire chg_fault;
    wire [W-1:0] ot_abs_dk;
    wire [W-1:0] ot_rel_dk;
    wire rm_grew;
    wire read_only;
    wire f_oc, f_tc, f_ot, f_td, f_rc, f_rt, f_in, f_dc, f_fc, f_fd;

    // Gauge logic runs only once the memory image was accepted
    assign run = (ee_state_q == EE_GOOD);
    assign load_good = (ee_state_q == EE_LOAD) && ee_load_done && !ee_load_fail
        && len_ok_q && chk_ok_q;
    assign load_bad = (ee_state_q == EE_LOAD)
        && (ee_load_fail || (ee_load_done && !(len_ok_q && chk_ok_q)));

    // Loader sequence: a new start reloads from idle, good or bad; during a load it only clears the checks
    always @* begin
        ee_state_d = ee_state_q;
        case (ee_state_q)
            EE_IDLE: begin
                if (ee_load_start) begin
                    ee_state_d = EE_LOAD;
                end
            end
            EE_LOAD: begin
                if (load_bad) begin
                    ee_state_d = EE_BAD;
                end else if (load_good) begin
                    ee_state_d = EE_GOOD;
                end
            end
            EE_GOOD, EE_BAD: begin
                if (ee_load_start) begin
                    ee_state_d = EE_LOAD;
                end
            end
            default: begin
                ee_state_d = EE_IDLE;
            end
        endcase
    end

    // Image checks and the initial status bytes, captured as they stream in
    always @(posedge core_clk) begin
        if (sys_rst) begin
            ee_state_q <= EE_IDLE;
            len_ok_q <= 1'b0;
            chk_ok_q <= 1'b0;
            init_word_q <= `BSEA_STATUS_RST;
            eeprom_valid_q <= 1'b0;
        end else begin
            ee_state_q <= ee_state_d;
            eeprom_valid_q <= (ee_state_d == EE_GOOD);
            if (ee_load_start) begin
                len_ok_q <= 1'b0;
                chk_ok_q <= 1'b0;
            end else if (ee_byte_valid && ee_state_q == EE_LOAD) begin
                if (ee_byte_addr == `BSEA_EE_LEN_ADDR) begin
                    len_ok_q <= (ee_byte_data == `BSEA_EE_LEN_VAL);
                end
                if (ee_byte_addr == `BSEA_EE_CHK_ADDR) begin
                    chk_ok_q <= (ee_byte_data == `BSEA_EE_CHK_VAL);
                end
                if (ee_byte_addr == `BSEA_EE_STAT_LO) begin
                    init_word_q[7:0] <= ee_byte_data;
                end
                if (ee_byte_addr == `BSEA_EE_STAT_HI) begin
                    init_word_q[15:8] <= ee_byte_data;
                end
            end
        end
    end

    // The status word itself is read-only, whatever the engine says
    assign read_only = cmd_read_only || (cmd_code == `BSEA_CMD_STATUS);

    // Outcome of the finishing command; a load in progress counts as busy
    always @* begin
        err_d = `BSEA_ERR_OK;
        if (cmd_busy || ee_state_q == EE_LOAD) begin
            err_d = `BSEA_ERR_BUSY;
        end else if (cmd_retry || ee_state_q != EE_GOOD) begin
            err_d = `BSEA_ERR_RETRY;
        end else if (!cmd_supported) begin
            err_d = `BSEA_ERR_UNSUPPORTED;
        end else if (cmd_write && read_only) begin
            err_d = `BSEA_ERR_ACCESS_DENIED;
        end else if (cmd_write && cmd_bad_size) begin
            err_d = `BSEA_ERR_BAD_SIZE;
        end else if (cmd_range_err) begin
            err_d = `BSEA_ERR_OVER_UNDER;
        end else if (cmd_other_err) begin
            err_d = `BSEA_ERR_UNKNOWN;
        end
    end

    // Every completion replaces the code, so a read after an error clears it
    // unless that read fails too; the newer error then wins over the clear
    always @(posedge core_clk) begin
        if (sys_rst) begin
            err_q <= `BSEA_ERR_OK;
            err_pend_q <= 1'b0;
        end else if (cmd_done) begin
            err_q <= err_d;
            err_pend_q <= (err_d != `BSEA_ERR_OK);
        end
    end

    // History for edge and growth detection
    always @(posedge core_clk) begin
        if (sys_rst) begin
            term_q <= 1'b0;
            rm_prev_q <= {W{1'b0}};
        end else begin
            term_q <= term_now;
            rm_prev_q <= remaining_capacity_count;
        end
    end

    assign term_now = is_charging && (dtdt_term || taper_term);
    assign term_rise = term_now && !term_q;
    assign chg_fault = is_charging
        && (over_current || over_voltage || f_ot || dtdt_term || taper_term);
    assign ot_abs_dk = `BSEA_ZERO_C_DK + `BSEA_OT_CLR_C * `BSEA_DK_PER_C;
    assign ot_rel_dk = minus_c(max_temperature, `BSEA_OT_HYST_C);
    assign rm_grew = is_charging && (remaining_capacity_count > rm_prev_q);

    // Alarm bits
    bsea_flag u_over_charged (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .load(load_good),
        .load_val(init_word_q[`BSEA_B_OVER_CHARGED]),
        .set(run && term_rise),
        .clr(run && (!is_charging || !term_now)),
        .q(f_oc)
    );

    bsea_flag u_term_charge (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .load(load_good),
        .load_val(init_word_q[`BSEA_B_TERM_CHARGE]),
        .set(run && chg_fault),
        .clr(run && !chg_fault),
        .q(f_tc)
    );

    // Cleared as soon as either the fixed or the relative limit is reached
    bsea_flag u_over_temp (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .load(load_good),
        .load_val(init_word_q[`BSEA_B_OVER_TEMP]),
        .set(run && (temperature > max_temperature)),
        .clr(run && (temperature <= ot_abs_dk || temperature <= ot_rel_dk)),
        .q(f_ot)
    );

    bsea_flag u_term_discharge (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .load(load_good),
        .load_val(init_word_q[`BSEA_B_TERM_DISCHARGE]),
        .set(run && (pack_voltage < final_discharge_voltage_threshold)),
        .clr(run && (pack_voltage > final_discharge_voltage_threshold)),
        .q(f_td)
    );

    bsea_flag u_rem_cap (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .load(load_good),
        .load_val(init_word_q[`BSEA_B_REM_CAP]),
        .set(run && (remaining_capacity_count < capacity_alarm_level)),
        .clr(run && ((capacity_alarm_level < remaining_capacity_count) || rm_grew)),
        .q(f_rc)
    );

    // Estimate only meaningful while discharging
    bsea_flag u_rem_time (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .load(load_good),
        .load_val(init_word_q[`BSEA_B_REM_TIME]),
        .set(run && !is_charging && (remaining_time_est < time_alarm_level)),
        .clr(run && ((time_alarm_level < avg_time_to_empty) || valid_charge)),
        .q(f_rt)
    );

    // Status bits; initialized follows the memory bit, not the run gate
    bsea_flag u_initialized (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .load(load_good),
        .load_val(ee_state_q == EE_LOAD && init_word_q[`BSEA_EE_INIT_BIT]),
        .set(1'b0),
        .clr(load_bad),
        .q(f_in)
    );

    bsea_flag u_discharging (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .load(load_good),
        .load_val(init_word_q[`BSEA_B_DISCHARGING]),
        .set(run && !is_charging),
        .clr(run && is_charging),
        .q(f_dc)
    );

    bsea_flag u_fully_charged (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .load(load_good),
        .load_val(init_word_q[`BSEA_B_FULLY_CHARGED]),
        .set(run && (term_rise || max_overcharge)),
        .clr(run && (remaining_capacity_count < full_charge_level)),
        .q(f_fc)
    );

    bsea_flag u_fully_discharged (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .load(load_good),
        .load_val(init_word_q[`BSEA_B_FULLY_DISCHARGED]),
        .set(run && (pack_voltage < final_discharge_voltage_threshold)),
        .clr(run && (relative_soc >= `BSEA_FD_CLR_PCT)),
        .q(f_fd)
    );

    // Word assembled from flops only; reserved bits 13 and 10 read zero
    assign battery_status_word = {f_oc, f_tc, 1'b0, f_ot, f_td, 1'b0, f_rc, f_rt,
        f_in, f_dc, f_fc, f_fd, err_q};
    assign eeprom_valid = eeprom_valid_q;
    assign error_pending = err_pend_q;
endmodule // bsea_status

// [test/bsea_status_checker.sv]
// Checker for the status word: error field and alarm bits.
// Assumes it is bound to bsea_status and sees only its ports.
`timescale 1ns/1ps
`include "bsea_consts.vh"

module bsea_status_checker #(
    parameter W = 16
) (
    input wire core_clk,
    input wire sys_rst,
    input wire ee_load_start,
    input wire cmd_done,
    input wire cmd_write,
    input wire [7:0] cmd_code,
    input wire cmd_supported,
    input wire cmd_read_only,
    input wire cmd_busy,
    input wire cmd_retry,
    input wire cmd_bad_size,
    input wire cmd_range_err,
    input wire cmd_other_err,
    input wire is_charging,
    input wire [W-1:0] temperature,
    input wire [W-1:0] max_temperature,
    input wire [W-1:0] pack_voltage,
    input wire [W-1:0] final_discharge_voltage_threshold,
    input wire [15:0] battery_status_word,
    input wire eeprom_valid,
    input wire error_pending
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // Image good and no reload starting at this edge
    wire ok = eeprom_valid && !ee_load_start;
    wire [3:0] err = battery_status_word[3:0];
    wire quiet = !(cmd_busy || cmd_retry || cmd_bad_size || cmd_range_err || cmd_other_err);
    wire good_cmd = cmd_done && ok && !cmd_busy && !cmd_retry;

    a_err_clean: assert property (good_cmd && cmd_supported && quiet && !cmd_write
        |=> err == 4'h0)
        else $error("clean command left a nonzero code");
    a_err_busy: assert property (cmd_done && cmd_busy |=> err == 4'h1)
        else $error("busy command not reported");
    a_err_retry: assert property (cmd_done && ok && !cmd_busy && cmd_retry |=> err == 4'h2)
        else $error("retry outcome not reported");
    a_not_loaded: assert property (cmd_done && !eeprom_valid && !ee_load_start && !cmd_busy
        |=> err inside {4'h1, 4'h2})
        else $error("command served without a good image");
    a_err_unsup: assert property (good_cmd && !cmd_supported |=> err == 4'h3)
        else $error("unsupported code not reported");
    a_err_denied: assert property (good_cmd && cmd_supported && cmd_write
        && (cmd_read_only || cmd_code == 8'h16) |=> err == 4'h4)
        else $error("write to read-only not reported");
    a_err_hold: assert property (!cmd_done |=> $stable(err))
        else $error("error field moved without a command");
    a_pending_match: assert property (error_pending == (err != 4'h0))
        else $error("pending flag disagrees with error field");
    a_over_temp: assert property (eeprom_valid && temperature > max_temperature
        |=> battery_status_word[12])
        else $error("over temperature alarm missing");
    a_term_dis: assert property (eeprom_valid
        && pack_voltage < final_discharge_voltage_threshold |=> battery_status_word[11])
        else $error("terminate discharge alarm missing");
    a_dis_follow: assert property (eeprom_valid
        |=> battery_status_word[6] == !$past(is_charging))
        else $error("discharging bit does not follow charge state");

    c_busy: cover property (cmd_done && cmd_busy);
    c_hot: cover property (eeprom_valid && temperature > max_temperature);
    c_loaded: cover property ($rose(eeprom_valid));
endmodule // bsea_status_checker

bind bsea_status bsea_status_checker #(.W(W)) chk_u (.*);

// [test/bsea_host.sv]
// Host model: one command completion with its outcome qualifiers per call.
// Assumes a single bench process calls send.
`timescale 1ns/1ps

module bsea_host (
    input wire core_clk,
    output reg cmd_done,
    output reg cmd_write,
    output reg [7:0] cmd_code,
    output reg [6:0] cmd_q
);
    // Idle values
    initial begin
        cmd_done = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_q = 7'h00;
    end

    // Qualifiers go inverted after use so stale values never pass as a fresh outcome
    task send(input w, input [7:0] c, input [6:0] q);
        begin
            @(posedge core_clk);
            cmd_done <= 1'b1;
            cmd_write <= w;
            cmd_code <= c;
            cmd_q <= q;
            @(posedge core_clk);
            cmd_done <= 1'b0;
            cmd_write <= ~w;
            cmd_code <= ~c;
            cmd_q <= ~q;
        end
    endtask
endmodule // bsea_host

// [test/testbench.sv]
// Self-checking bench for the status word block.
// Assumes bsea_host models the command side; q = {sup, ro, busy, retry, size, range, other}.
`timescale 1ns/1ps

`define E @(posedge core_clk)
`define CHK(a, b) begin checks = checks + 1; if ((a) !== (b)) begin \
    failures = failures + 1; $display("mismatch t=%0t got %h exp %h", $time, a, b); end end

module testbench;
    reg core_clk = 1'b0, sys_rst = 1'b1, ee_load_start = 1'b0, ee_byte_valid = 1'b0;
    reg ee_load_done = 1'b0, is_charging = 1'b0, dtdt_term = 1'b0, taper_term = 1'b0;
    reg ee_load_fail = 1'b0, over_current = 1'b0, max_overcharge = 1'b0;
    reg [7:0] ee_byte_addr = 8'h00, ee_byte_data = 8'h00;
    reg [15:0] temperature = 16'h0bb8, max_temperature = 16'h0c9f;
    reg [15:0] pack_voltage = 16'h3000, final_discharge_voltage_threshold = 16'h2000;
    reg [15:0] remaining_capacity_count = 16'h0100, capacity_alarm_level = 16'h0080;
    reg [15:0] remaining_time_est = 16'h0100, time_alarm_level = 16'h0080;
    reg [6:0] relative_soc = 7'd50;
    wire cmd_done, cmd_write, eeprom_valid, error_pending;
    wire [7:0] cmd_code;
    wire [6:0] cq;
    wire [15:0] bsw;
    integer failures = 0, checks = 0;

    bsea_host host_u (.core_clk(core_clk), .cmd_done(cmd_done), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_q(cq));

    // Protection inputs not modelled here are tied off
    bsea_status #(.W(16)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
        .ee_load_start(ee_load_start), .ee_byte_valid(ee_byte_valid),
        .ee_byte_addr(ee_byte_addr), .ee_byte_data(ee_byte_data),
        .ee_load_done(ee_load_done), .ee_load_fail(ee_load_fail), .cmd_done(cmd_done),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_supported(cq[6]),
        .cmd_read_only(cq[5]), .cmd_busy(cq[4]), .cmd_retry(cq[3]), .cmd_bad_size(cq[2]),
        .cmd_range_err(cq[1]), .cmd_other_err(cq[0]), .is_charging(is_charging),
        .valid_charge(1'b0), .dtdt_term(dtdt_term), .taper_term(taper_term),
        .over_current(over_current), .over_voltage(1'b0), .max_overcharge(max_overcharge),
        .temperature(temperature), .max_temperature(max_temperature),
        .pack_voltage(pack_voltage),
        .final_discharge_voltage_threshold(final_discharge_voltage_threshold),
        .remaining_capacity_count(remaining_capacity_count),
        .capacity_alarm_level(capacity_alarm_level), .full_charge_level(16'h0f00),
        .remaining_time_est(remaining_time_est), .time_alarm_level(time_alarm_level),
        .avg_time_to_empty(16'h0100), .relative_soc(relative_soc),
        .battery_status_word(bsw), .eeprom_valid(eeprom_valid),
        .error_pending(error_pending));

    // 25 MHz clock
    initial begin
        forever #20 core_clk = ~core_clk;
    end

    task results;
        begin
            $display("checks=%0d failures=%0d", checks, failures);
            if (failures == 0 && checks > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask

    task nx;
        begin
            `E;
            #1;
        end
    endtask

    task put(input [7:0] a, input [7:0] d);
        begin
            `E;
            ee_byte_valid <= 1'b1;
            ee_byte_addr <= a;
            ee_byte_data <= d;
        end
    endtask

    // Command through the host, then error field and pending flag
    task sx(input w, input [7:0] c, input [6:0] q, input [3:0] e);
        begin
            host_u.send(w, c, q);
            #1;
            `CHK(bsw[3:0], e)
            `CHK(error_pending, e != 4'h0)
        end
    endtask

    // Image load; a wrong check byte or a loader failure must leave the block unloaded
    task t_load(input [7:0] chk, input [7:0] lo, input fl, input ok);
        begin
            `E;
            ee_load_start <= 1'b1;
            `E;
            ee_load_start <= 1'b0;
            put(8'h00, 8'h64);
            put(8'h01, chk);
            put(8'h0c, lo);
            put(8'h0d, 8'h00);
            `E;
            ee_byte_valid <= 1'b0;
            ee_load_done <= !fl;
            ee_load_fail <= fl;
            `E;
            ee_load_done <= 1'b0;
            ee_load_fail <= 1'b0;
            #1;
            `CHK(eeprom_valid, ok)
            `CHK(bsw[7], ok & lo[7])
            $display("test load done");
        end
    endtask

    // Every outcome code, back to back, then a clean read clears
    task t_err;
        begin
            sx(1'b0, 8'h09, 7'b1000000, 4'h0);
            sx(1'b1, 8'h09, 7'b1010000, 4'h1);
            sx(1'b0, 8'h09, 7'b1001000, 4'h2);
            sx(1'b0, 8'h55, 7'b0000000, 4'h3);
            sx(1'b1, 8'h09, 7'b1100000, 4'h4);
            sx(1'b1, 8'h16, 7'b1000000, 4'h4);
            sx(1'b0, 8'h09, 7'b1000010, 4'h5);
            sx(1'b1, 8'h09, 7'b1000100, 4'h6);
            sx(1'b0, 8'h09, 7'b1000001, 4'h7);
            sx(1'b0, 8'h0d, 7'b1000000, 4'h0);
            $display("test errors done");
        end
    endtask

    // Alarm and status bits at their set and clear boundaries
    task t_flags;
        begin
            nx;
            `CHK(bsw[6], 1'b1)
            `E; temperature <= 16'h0ca0; nx; `CHK(bsw[12], 1'b1)
            `E; temperature <= 16'h0c6e; nx; `CHK(bsw[12], 1'b1)
            `E; temperature <= 16'h0c6d; nx; `CHK(bsw[12], 1'b0)
            `E; pack_voltage <= 16'h1fff; nx; `CHK(bsw[11], 1'b1)
            `CHK(bsw[4], 1'b1)
            `E; pack_voltage <= 16'h2001; relative_soc <= 7'd19; nx; `CHK(bsw[11], 1'b0)
            `CHK(bsw[4], 1'b1)
            `E; relative_soc <= 7'd20; nx; `CHK(bsw[4], 1'b0)
            `E; remaining_capacity_count <= 16'h007f; nx; `CHK(bsw[9], 1'b1)
            `E; capacity_alarm_level <= 16'h007e; nx; `CHK(bsw[9], 1'b0)
            `E; remaining_time_est <= 16'h007f; nx; `CHK(bsw[8], 1'b1)
            `E; time_alarm_level <= 16'h007e; nx; `CHK(bsw[8], 1'b0)
            `E; is_charging <= 1'b1; nx; `CHK(bsw[6], 1'b0)
            `E; dtdt_term <= 1'b1; nx; `CHK(bsw[15:14], 2'b11)
            `CHK(bsw[5], 1'b1)
            `E; dtdt_term <= 1'b0; nx; `CHK(bsw[15:14], 2'b00)
            `CHK(bsw[5], 1'b0)
            `E; is_charging <= 1'b0;
            $display("test flags done");
        end
    endtask

    // Charge fault and overcharge while charging
    task t_fault;
        begin
            `E; is_charging <= 1'b1; over_current <= 1'b1; nx; `CHK(bsw[14], 1'b1)
            `E; over_current <= 1'b0; nx; `CHK(bsw[14], 1'b0)
            `E; max_overcharge <= 1'b1; nx; `CHK(bsw[5], 1'b1)
            `E; max_overcharge <= 1'b0; is_charging <= 1'b0; nx; `CHK(bsw[5], 1'b0)
            $display("test faults done");
        end
    endtask

    // Hang guard
    initial begin
        repeat (5000) `E;
        failures = failures + 1;
        results;
    end

    // Main sequence
    initial begin
        repeat (20) `E;
        sys_rst <= 1'b0;
        nx;
        `CHK(bsw, 16'h0000)
        sx(1'b0, 8'h09, 7'b1000000, 4'h2);
        t_load(8'h5b, 8'h80, 1'b0, 1'b1);
        t_err;
        t_flags;
        t_fault;
        t_load(8'h5b, 8'h80, 1'b1, 1'b0);
        t_load(8'h5b, 8'h80, 1'b0, 1'b1);
        t_load(8'h5a, 8'h80, 1'b0, 1'b0);
        sx(1'b0, 8'h09, 7'b1000000, 4'h2);
        results;
    end
endmodule // testbench
